// *** verilog/lcdch_pkg.sv ***
package lcdch_pkg;

    // Command codes, low six type bits
    localparam logic [5:0] CMD_VERSION = 6'h01, CMD_USER_WR = 6'h02, CMD_USER_RD = 6'h03,
                           CMD_SAVE = 6'h04, CMD_RESTART = 6'h05, CMD_CLEAR = 6'h06,
                           CMD_LINE_TOP = 6'h07, CMD_LINE_BOT = 6'h08, CMD_GLYPH = 6'h09,
                           CMD_MEM_RD = 6'h0a, CMD_CURSOR_POS = 6'h0b,
                           CMD_CURSOR_STYLE = 6'h0c, CMD_CONTRAST = 6'h0d;
    localparam logic [1:0] RSP_OK = 2'h1, RSP_ERR = 2'h3, CMD_CLASS = 2'h0;
    // Restart keys, three payload bytes each
    localparam logic [23:0] KEY_SELF = 24'h081263, KEY_HOST_RESET = 24'h0c1c61,
                            KEY_HOST_OFF = 24'h030b5f;
    // Sizes
    localparam int MAX_PAYLOAD = 18, USER_BYTES = 16, LINE_CHARS = 16, DISP_BYTES = 32;
    localparam int GLYPH_ROWS = 8, IMG_BYTES = 96, MEM_RD_LEN = 9;
    // Parameter limits and fill values
    localparam logic [7:0] BLANK_CHAR = 8'h20, GLYPH_ROW_MAX = 8'h3f, GLYPH_IDX_MAX = 8'h07;
    localparam logic [7:0] COL_MAX = 8'h0f, ROW_MAX = 8'h01, STYLE_MAX = 8'h03;
    localparam logic [7:0] CONTRAST_MAX = 8'hc8, CONTRAST_RST = 8'h10;
    // Memory read address codes, upper two bits
    localparam logic [1:0] MEMCODE_DISP = 2'h2, MEMCODE_GLYPH = 2'h1;
    // Answer deadline
    localparam int ANSWER_LIMIT_MS = 250, CLK_FREQ_HZ = 125_000_000;
    localparam int ANSWER_LIMIT_CYC = ANSWER_LIMIT_MS * (CLK_FREQ_HZ / 1000);
    // Version text, arbitrary neutral value
    localparam logic [127:0] VERSION_TEXT = "HW:1h0, FW:0u0  ";
    // Register map and reset values
    localparam logic [7:0] REG_CTRL = 8'h00, REG_STATUS = 8'h04;
    localparam int CTRL_GPIO3_BIT = 0, CTRL_GPIO2_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h3;

    typedef struct packed {
        logic [3:0] col;
        logic       row;
        logic [1:0] style;
        logic [7:0] contrast;
        logic       fine;
    } lcdch_view_t;
    typedef struct packed {
        logic       sop;
        logic       eop;
        logic [7:0] data;
    } lcdch_beat_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } lcdch_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lcdch_apb_rsp_t;
endpackage

// *** verilog/lcdch_cmd_handler.sv ***
`timescale 1ns/1ns
module lcdch_cmd_handler #(
    parameter int ANSWER_LIMIT = lcdch_pkg::ANSWER_LIMIT_CYC // Cycles allowed per answer
) (
    input  logic                     sys_clk,        // Module clock, 125 MHz
    input  logic                     rst_n,          // Synchronous reset, power-on
    input  logic                     ce,             // Clock enable, freezes state
    input  lcdch_pkg::lcdch_apb_req_t apb_req,       // APB request
    output lcdch_pkg::lcdch_apb_rsp_t apb_rsp,       // APB answer
    input  logic                     cmd_valid,      // Command byte offered
    input  lcdch_pkg::lcdch_beat_t   cmd_beat,       // Command byte, sop marks type
    output logic                     cmd_ready,      // Command byte taken
    output logic                     rsp_valid,      // Answer byte offered
    output lcdch_pkg::lcdch_beat_t   rsp_beat,       // Answer byte, sop marks type
    input  logic                     rsp_ready,      // Answer byte taken
    output lcdch_pkg::lcdch_view_t   view,           // Cursor and contrast state
    output logic                     host_reset_req, // Pulse on pin three
    output logic                     host_off_req,   // Pulse on pin two
    output logic                     self_restart,   // Pulse, simulated power-on
    output logic                     sensor_reenum,  // Pulse, sensor scan request
    output logic                     boot_saved      // Pulse, boot state written
);
    import lcdch_pkg::*;

    typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_RX, ST_EXEC, ST_CHECK, ST_SEND} lcdch_state_t;
    localparam int ANS_W = $clog2(ANSWER_LIMIT + 1);

    lcdch_state_t state_q, state_d;
    logic [7:0]  type_q, len_q;
    logic [4:0]  pcnt_q;
    logic        got_len_q;
    logic [7:0]  pay_q  [MAX_PAYLOAD];
    logic [7:0]  img_q  [IMG_BYTES];
    logic [7:0]  img_d  [IMG_BYTES];
    logic [7:0]  boot_q [IMG_BYTES];
    logic [7:0]  boot_d [IMG_BYTES];
    logic [7:0]  user_q [USER_BYTES];
    logic [7:0]  rbuf_q [MAX_PAYLOAD];
    logic [7:0]  rbuf_d [MAX_PAYLOAD];
    logic [7:0]  mem_rd [GLYPH_ROWS];
    lcdch_view_t view_q, view_d, bview_q;
    logic [1:0]  ctrl_q;
    logic [7:0]  rtype_q;
    logic [4:0]  rlen_q, rlen_d, sidx_q;
    logic [ANS_W-1:0] ans_q;
    logic        restart_pend_q;
    logic        hrst_q, hoff_q, self_q, boot_saved_q;
    logic        cmd_ok;
    logic [GLYPH_ROWS-1:0] row_ok;

    function automatic logic key_is(input logic [23:0] got, input logic [23:0] key);
        return got == key;
    endfunction

    // Command byte intake; beats outside a packet are dropped to resync
    wire rx_fire  = cmd_valid && cmd_ready;
    wire rx_start = rx_fire && cmd_beat.sop;
    wire rx_end   = rx_fire && cmd_beat.eop && (cmd_beat.sop || state_q == ST_RX);
    assign cmd_ready = ce && (state_q == ST_IDLE || state_q == ST_RX);

    // Header decode
    wire [5:0]  cmd  = type_q[5:0];
    wire [23:0] key3 = {pay_q[0], pay_q[1], pay_q[2]};
    wire hdr_ok = got_len_q && type_q[7:6] == CMD_CLASS && len_q <= 8'(MAX_PAYLOAD)
                  && {3'h0, pcnt_q} == len_q;
    wire len0  = hdr_ok && len_q == 8'h00;
    wire len1  = hdr_ok && len_q == 8'h01;
    wire len2  = hdr_ok && len_q == 8'h02;
    wire len3  = hdr_ok && len_q == 8'h03;
    wire len9  = hdr_ok && len_q == 8'(MEM_RD_LEN);
    wire len16 = hdr_ok && len_q == 8'(USER_BYTES);
    wire k_self  = key_is(key3, KEY_SELF);
    wire k_hrst  = key_is(key3, KEY_HOST_RESET);
    wire k_hoff  = key_is(key3, KEY_HOST_OFF);
    wire mem_disp  = pay_q[0][7:6] == MEMCODE_DISP;
    wire mem_glyph = pay_q[0][7:6] == MEMCODE_GLYPH;

    // Per-row glyph range check and eight-byte memory readback
    for (genvar g = 0; g < GLYPH_ROWS; g++) begin : g_row
        wire [4:0] di = pay_q[0][4:0] + 5'(g);
        wire [5:0] gi = pay_q[0][5:0] + 6'(g);
        assign row_ok[g] = pay_q[g+1] <= GLYPH_ROW_MAX;
        assign mem_rd[g] = mem_disp ? img_q[7'(di)] : img_q[7'(DISP_BYTES) + 7'(gi)];
    end

    // Acceptance per command; anything else earns an error
    always_comb begin
        case (cmd)
            CMD_VERSION:      cmd_ok = len0;
            CMD_USER_WR:      cmd_ok = len16;
            CMD_USER_RD:      cmd_ok = len0;
            CMD_SAVE:         cmd_ok = len0;
            CMD_RESTART:      cmd_ok = len3 && (k_self || k_hrst || k_hoff);
            CMD_CLEAR:        cmd_ok = len0;
            CMD_LINE_TOP:     cmd_ok = len16;
            CMD_LINE_BOT:     cmd_ok = len16;
            CMD_GLYPH:        cmd_ok = len9 && pay_q[0] <= GLYPH_IDX_MAX && &row_ok;
            CMD_MEM_RD:       cmd_ok = len1 && (mem_disp || mem_glyph);
            CMD_CURSOR_POS:   cmd_ok = len2 && pay_q[0] <= COL_MAX && pay_q[1] <= ROW_MAX;
            CMD_CURSOR_STYLE: cmd_ok = len1 && pay_q[0] <= STYLE_MAX;
            // coarse 0-200; fine takes any first byte
            CMD_CONTRAST:     cmd_ok = (len1 && pay_q[0] <= CONTRAST_MAX) || len2;
            default:          cmd_ok = 1'b0;
        endcase
    end
    wire exec_ok = state_q == ST_EXEC && cmd_ok;

    // Display and glyph image; the load copies boot state in one cycle
    always_comb begin
        img_d = img_q;
        if (state_q == ST_LOAD) begin
            img_d = boot_q;
        end else if (exec_ok) begin
            for (int i = 0; i < DISP_BYTES; i++) begin
                if (cmd == CMD_CLEAR) begin
                    img_d[i] = BLANK_CHAR;
                end
                if (cmd == CMD_LINE_TOP && i < LINE_CHARS) begin
                    img_d[i] = pay_q[i];
                end
                if (cmd == CMD_LINE_BOT && i >= LINE_CHARS) begin
                    img_d[i] = pay_q[i-LINE_CHARS];
                end
            end
            if (cmd == CMD_GLYPH) begin
                for (int r = 0; r < GLYPH_ROWS; r++) begin
                    img_d[DISP_BYTES + 8*int'(pay_q[0][2:0]) + r] = pay_q[r+1];
                end
            end
        end
    end

    // Cursor and contrast
    always_comb begin
        view_d = view_q;
        if (state_q == ST_LOAD) begin
            view_d = bview_q;
        end else if (exec_ok) begin
            case (cmd)
                CMD_CLEAR: begin
                    view_d.col = 4'h0;
                    view_d.row = 1'b0;
                end
                CMD_CURSOR_POS: begin
                    view_d.col = pay_q[0][3:0];
                    view_d.row = pay_q[1][0];
                end
                CMD_CURSOR_STYLE: view_d.style = pay_q[0][1:0];
                CMD_CONTRAST: begin
                    view_d.contrast = len2 ? pay_q[1] : pay_q[0];
                    view_d.fine     = len2;
                end
                default: ;
            endcase
        end
    end

    // Boot store; reporting enables and watchdog are not kept here
    always_comb begin
        boot_d = boot_q;
        if (exec_ok && cmd == CMD_SAVE) begin
            boot_d = img_q;
        end
    end
    wire save_mismatch = (boot_q != img_q) || (bview_q != view_q);

    // Answer payload
    always_comb begin
        rbuf_d = rbuf_q;
        rlen_d = 5'h00;
        for (int k = 0; k < USER_BYTES; k++) begin
            if (cmd == CMD_VERSION) begin
                rbuf_d[k] = VERSION_TEXT[8*(USER_BYTES-1-k) +: 8];
            end
            if (cmd == CMD_USER_RD) begin
                rbuf_d[k] = user_q[k];
            end
        end
        if (cmd == CMD_MEM_RD) begin
            rbuf_d[0] = pay_q[0];
            for (int k = 0; k < GLYPH_ROWS; k++) begin
                rbuf_d[k+1] = mem_rd[k];
            end
        end
        if (cmd_ok && (cmd == CMD_VERSION || cmd == CMD_USER_RD)) begin
            rlen_d = 5'(USER_BYTES);
        end else if (cmd_ok && cmd == CMD_MEM_RD) begin
            rlen_d = 5'(MEM_RD_LEN);
        end
    end

    // Answer streaming: type, length, then payload
    wire [7:0] rsp_byte = (sidx_q == 5'h00) ? rtype_q
                        : (sidx_q == 5'h01) ? {3'h0, rlen_q} : rbuf_q[sidx_q - 5'h02];
    wire rsp_last  = sidx_q == rlen_q + 5'h01;
    wire rsp_fire  = rsp_valid && rsp_ready;
    // abandon a stalled answer at the deadline, host retries
    wire ans_expired = state_q == ST_SEND && ans_q >= ANS_W'(ANSWER_LIMIT - 1);
    assign rsp_valid = ce && state_q == ST_SEND;
    assign rsp_beat  = '{sop: sidx_q == 5'h00, eop: rsp_last, data: rsp_byte};

    // Sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_LOAD: state_d = ST_IDLE;
            ST_IDLE, ST_RX: begin
                if (rx_end) begin
                    state_d = ST_EXEC;
                end else if (rx_start) begin
                    state_d = ST_RX;
                end
            end
            ST_EXEC:  state_d = (exec_ok && cmd == CMD_SAVE) ? ST_CHECK : ST_SEND;
            ST_CHECK: state_d = ST_SEND;
            ST_SEND: begin
                if ((rsp_fire && rsp_last) || ans_expired) begin
                    state_d = restart_pend_q ? ST_LOAD : ST_IDLE;
                end
            end
        endcase
    end

    // State and image storage; reset is the power-on default
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_LOAD;
            // Text area blank, glyph area clear
            for (int i = 0; i < IMG_BYTES; i++) begin
                img_q[i]  <= (i < DISP_BYTES) ? BLANK_CHAR : 8'h00;
                boot_q[i] <= (i < DISP_BYTES) ? BLANK_CHAR : 8'h00;
            end
            view_q  <= '{col: 4'h0, row: 1'b0, style: 2'h0, contrast: CONTRAST_RST, fine: 1'b0};
            bview_q <= '{col: 4'h0, row: 1'b0, style: 2'h0, contrast: CONTRAST_RST, fine: 1'b0};
        end else if (ce) begin
            state_q <= state_d;
            img_q   <= img_d;
            boot_q  <= boot_d;
            view_q  <= view_d;
            if (exec_ok && cmd == CMD_SAVE) begin
                bview_q <= view_q;
            end
        end
    end

    // Packet capture
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            type_q    <= 8'h00;
            len_q     <= 8'h00;
            pcnt_q    <= 5'h00;
            got_len_q <= 1'b0;
            pay_q     <= '{default: 8'h00};
        end else if (ce && rx_start) begin
            type_q    <= cmd_beat.data;
            pcnt_q    <= 5'h00;
            got_len_q <= 1'b0;
        end else if (ce && rx_fire && state_q == ST_RX) begin
            if (!got_len_q) begin
                len_q     <= cmd_beat.data;
                got_len_q <= 1'b1;
            end else if (pcnt_q <= 5'(MAX_PAYLOAD)) begin
                pcnt_q <= pcnt_q + 5'h01;
                if (pcnt_q < 5'(MAX_PAYLOAD)) begin
                    pay_q[pcnt_q] <= cmd_beat.data;
                end
            end
        end
    end

    // User area; held across restart, only power-on clears it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            user_q <= '{default: 8'h00};
        end else if (ce && exec_ok && cmd == CMD_USER_WR) begin
            for (int k = 0; k < USER_BYTES; k++) begin
                user_q[k] <= pay_q[k];
            end
        end
    end

    // Answer build and send index
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rtype_q <= 8'h00;
            rlen_q  <= 5'h00;
            rbuf_q  <= '{default: 8'h00};
            sidx_q  <= 5'h00;
        end else if (ce) begin
            if (state_q == ST_EXEC) begin
                rtype_q <= {cmd_ok ? RSP_OK : RSP_ERR, cmd};
                rlen_q  <= rlen_d;
                rbuf_q  <= rbuf_d;
                sidx_q  <= 5'h00;
            end else if (state_q == ST_CHECK && save_mismatch) begin
                rtype_q <= {RSP_ERR, cmd};
            end else if (rsp_fire) begin
                sidx_q <= sidx_q + 5'h01;
            end
        end
    end

    // Deadline counter, runs from packet end to last answer byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ans_q <= '0;
        end else if (ce) begin
            if (state_q == ST_IDLE || state_q == ST_RX || state_q == ST_LOAD) begin
                ans_q <= '0;
            end else if (!ans_expired) begin
                ans_q <= ans_q + 1'b1;
            end
        end
    end

    // Side-effect pulses; restart waits for its ack to leave first
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            restart_pend_q <= 1'b0;
            hrst_q         <= 1'b0;
            hoff_q         <= 1'b0;
            self_q         <= 1'b0;
            boot_saved_q   <= 1'b0;
        end else if (ce) begin
            restart_pend_q <= (exec_ok && cmd == CMD_RESTART && k_self)
                              || (restart_pend_q && state_q != ST_LOAD);
            self_q         <= state_q == ST_LOAD && restart_pend_q;
            // host reset pulse; pin wiring in CTRL
            hrst_q <= exec_ok && cmd == CMD_RESTART && k_hrst && ctrl_q[CTRL_GPIO3_BIT];
            hoff_q <= exec_ok && cmd == CMD_RESTART && k_hoff && ctrl_q[CTRL_GPIO2_BIT];
            boot_saved_q   <= state_q == ST_CHECK && !save_mismatch;
        end
    end
    assign host_reset_req = hrst_q;
    assign host_off_req   = hoff_q;
    assign self_restart   = self_q;
    assign sensor_reenum  = self_q;
    assign boot_saved     = boot_saved_q;
    assign view           = view_q;

    // APB slave, zero wait states while enabled
    wire        apb_acc    = apb_req.psel && apb_req.penable;
    wire        sel_ctrl   = apb_req.paddr == REG_CTRL;
    wire        sel_status = apb_req.paddr == REG_STATUS;
    wire [31:0] status_w   = {15'h0000, state_q != ST_IDLE, view_q.contrast, view_q.fine,
                              view_q.style, view_q.row, view_q.col};
    wire [31:0] rd_word    = sel_ctrl ? {30'h0, ctrl_q} : sel_status ? status_w : 32'h0;
    assign apb_rsp = '{prdata: rd_word, pready: ce,
                       pslverr: apb_acc && !(sel_ctrl || sel_status)};

    // Control register write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
        end else if (ce && apb_acc && apb_req.pwrite && sel_ctrl) begin
            ctrl_q <= apb_req.pwdata[1:0];
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_exec(logic [5:0] c);
        ce && exec_ok && cmd == c;
    endsequence
    sequence s_ack_done;
        ce && rsp_fire && rsp_last && restart_pend_q;
    endsequence

    AST_ACK_TYPE: assert property (rsp_valid && rsp_beat.sop |->
        rsp_beat.data[5:0] == type_q[5:0]) else $error("answer type bits differ");
    AST_VERSION: assert property (s_exec(CMD_VERSION) |=>
        rtype_q == 8'h41 && rlen_q == 5'(USER_BYTES)) else $error("version answer wrong");
    AST_USER_WR: assert property (s_exec(CMD_USER_WR) |=>
        user_q[USER_BYTES-1] == $past(pay_q[USER_BYTES-1])) else $error("user write lost");
    AST_USER_RD: assert property (s_exec(CMD_USER_RD) |=>
        rbuf_q[0] == user_q[0] && rtype_q == 8'h43) else $error("user read wrong");
    AST_CLEAR: assert property (s_exec(CMD_CLEAR) |=>
        img_q[DISP_BYTES-1] == BLANK_CHAR && view_q.col == 4'h0 && !view_q.row)
        else $error("clear incomplete");
    AST_REJECT: assert property (ce && state_q == ST_EXEC && !cmd_ok |=>
        $stable(view_q) && rtype_q[7:6] == RSP_ERR) else $error("bad command changed state");
    AST_HOST_RESET: assert property (s_exec(CMD_RESTART) and (k_hrst && ctrl_q[0]) |=>
        host_reset_req ##1 (!host_reset_req || !$past(ce))) else $error("host reset pulse wrong");
    AST_REBOOT: assert property (s_ack_done |=> state_q == ST_LOAD ##1
        (!$past(ce) or self_restart)) else $error("restart not performed");
    AST_SAVE_CHECK: assert property (ce && state_q == ST_CHECK |=>
        (rtype_q[7:6] == RSP_ERR) != boot_saved) else $error("save mismatch not reported");
    AST_ANSWER: assert property (state_q == ST_SEND |->
        ans_q < ANS_W'(ANSWER_LIMIT)) else $error("answer deadline passed");
endmodule // lcdch_cmd_handler

// *** verification/lcdch_host_model.sv ***
`timescale 1ns/1ns
// Host end of the answer stream: takes bytes, stalls now and then
module lcdch_host_model (
    input  wire logic                   sys_clk,   // Module clock
    input  wire logic                   rsp_valid, // Answer byte offered
    input  wire lcdch_pkg::lcdch_beat_t rsp_beat,  // Answer byte
    output logic                        rsp_ready  // Answer byte taken
);
    import lcdch_pkg::*;
    lcdch_beat_t rx_q[$];
    logic [3:0] lfsr_q = 4'h9;
    // host collects answers
    // A slow host must still get its whole answer in time
    always @(posedge sys_clk) begin
        lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
        rsp_ready <= lfsr_q[0] | lfsr_q[1];
        if (rsp_valid && rsp_ready)
            rx_q.push_back(rsp_beat);
    end
endmodule // lcdch_host_model

// *** verification/test_lcd_module_command_handler.sv ***
`timescale 1ns/1ns
module test_lcd_module_command_handler;
    import lcdch_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, ce = 1'b1, perr;
    lcdch_apb_req_t apb_req = '0;
    lcdch_apb_rsp_t apb_rsp;
    lcdch_beat_t cmd_beat = '0, rsp_beat;
    lcdch_view_t view;
    logic cmd_ready, rsp_valid, rsp_ready, hrst, hoff, srst, reen, saved;
    int num_errors = 0, samples_checked = 0, npulse = 0, cyc = 0;
    logic [31:0] seed = 32'h5f9b, rd, prd;
    logic [7:0] pl[$], ex[$], usr[$], g[$];
    lcdch_cmd_handler #(.ANSWER_LIMIT(200)) i_lcdch_cmd_handler (.sys_clk, .rst_n,
        .ce, .apb_req, .apb_rsp, .cmd_valid, .cmd_beat, .cmd_ready, .rsp_valid,
        .rsp_beat, .rsp_ready, .view, .host_reset_req(hrst), .host_off_req(hoff),
        .self_restart(srst), .sensor_reenum(reen), .boot_saved(saved));
    lcdch_host_model i_lcdch_host_model (.sys_clk, .rsp_valid, .rsp_beat, .rsp_ready);
    initial forever #4 sys_clk = ~sys_clk;
    // Random clock-enable gaps; pulses stand while frozen, so tally on enabled edges
    always @(posedge sys_clk) begin
        ce <= !rst_n || ((rnd() & 32'h7) != 32'h0);
        if (ce)
            npulse <= npulse + hrst + 2 * hoff + 4 * srst + 8 * saved + 16 * reen;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1);
        prd = apb_rsp.prdata;
        perr = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge sys_clk);
    endtask
    // Send pl under type t; expect type et with payload ex
    task automatic xfer(logic [7:0] t, logic [7:0] et);
        int i;
        logic [7:0] pk[$];
        pk = {t, 8'(pl.size()), pl};
        for (i = 0; i < pk.size(); i++) begin
            cmd_valid <= 1'b1;
            cmd_beat <= '{i == 0, i == pk.size() - 1, pk[i]};
            do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        end
        cmd_valid <= 1'b0;
        ex = {et, 8'(ex.size()), ex};
        for (i = 0; i < 300 && i_lcdch_host_model.rx_q.size() < ex.size(); i++)
            @(posedge sys_clk);
        for (i = 0; i < ex.size(); i++)
            chk("answer byte", {i == 0, i == ex.size() - 1, ex[i]}, i_lcdch_host_model.rx_q[i]);
        i_lcdch_host_model.rx_q.delete();
        pl = {};
        ex = {};
        @(posedge sys_clk);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (int k = 15; k >= 0; k--)
            ex.push_back(VERSION_TEXT[8*k +: 8]);
        xfer(8'h01, 8'h41);
        xfer(8'h00, 8'hc0);
        repeat (16) usr.push_back(8'(rnd()));
        pl = usr;
        xfer(8'h02, 8'h42);
        pl = usr[0:14];
        xfer(8'h02, 8'hc2);
        ex = usr;
        xfer(8'h03, 8'h43);
        for (int s = 0; s < 5; s++) begin
            pl = {8'(s)};
            xfer(8'h0c, s < 4 ? 8'h4c : 8'hcc);
            chk("style", s < 4 ? s : 3, view.style);
        end
        rd = rnd();
        pl = {8'(rd[3:0]), 8'(rd[4])};
        xfer(8'h0b, 8'h4b);
        pl = {8'h10, 8'h00};
        xfer(8'h0b, 8'hcb);
        chk("cursor", rd[4:0], {view.row, view.col});
        pl = {8'hc8};
        xfer(8'h0d, 8'h4d);
        pl = {8'hc9};
        xfer(8'h0d, 8'hcd);
        chk("contrast", 32'h190, {view.contrast, view.fine});
        pl = {8'hff, rd[15:8]};
        xfer(8'h0d, 8'h4d);
        apb(1'b0, 8'h04, 32'h0);
        chk("status", {rd[15:8], 3'h7, rd[4:0]}, prd);
        apb(1'b0, 8'h08, 32'h0);
        chk("slverr", 1, perr);
        xfer(8'h04, 8'h44);
        pl = {8'h00, 8'h00};
        xfer(8'h0b, 8'h4b);
        pl = {8'h08, 8'h12, 8'h63};
        xfer(8'h05, 8'h45);
        repeat (8) @(posedge sys_clk);
        chk("reloaded cursor", rd[4:0], {view.row, view.col});
        pl = {8'h0c, 8'h1c, 8'h61};
        xfer(8'h05, 8'h45);
        pl = {8'h03, 8'h0b, 8'h5f};
        xfer(8'h05, 8'h45);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 0, prd);
        pl = {8'h0c, 8'h1c, 8'h61};
        xfer(8'h05, 8'h45);
        chk("pulses", 31, npulse);
        pl = usr;
        xfer(8'h08, 8'h48);
        xfer(8'h06, 8'h46);
        chk("home", 0, {view.row, view.col});
        pl = usr;
        xfer(8'h07, 8'h47);
        pl = {8'h80};
        ex = {8'h80, usr[0:7]};
        xfer(8'h0a, 8'h4a);
        pl = {8'h90};
        ex = {8'h90};
        repeat (8) ex.push_back(BLANK_CHAR);
        xfer(8'h0a, 8'h4a);
        pl = {8'h07};
        for (int k = 0; k < 8; k++)
            pl.push_back(usr[k] & GLYPH_ROW_MAX);
        g = pl[1:8];
        xfer(8'h09, 8'h49);
        pl = {8'h78};
        ex = {8'h78, g};
        xfer(8'h0a, 8'h4a);
        end_of_test();
    end
endmodule // test_lcd_module_command_handler
